// [hw/abe_engine.sv]
// block cipher engine: 128-bit key and state memories, fixed-latency operation, AXI4-Lite slave
//
// What this block does
// - 128-bit block, 128-bit key, encrypt or decrypt
// - result readable 375 cycles after start
// - completion interrupt when software enables it
// - DMA trigger pulse on every completion
// - auto-start after last state byte written
// - XOR load mode for state writes
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module abe_engine
   import abe_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ABE_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ABE_DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ABE_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [ABE_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq,
   output logic dma_trig
);
   // finite field helpers
   function automatic logic [7:0] xt(input logic [7:0] a);
      xt = {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
   endfunction

   function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] x;
      p = 8'h00;
      x = a;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) begin
            p = p ^ x;
         end
         x = xt(x);
      end
      gmul = p;
   endfunction

   // multiplicative inverse as x^254; zero maps to zero
   function automatic logic [7:0] ginv(input logic [7:0] a);
      logic [7:0] r;
      logic [7:0] p;
      r = 8'h01;
      p = a;
      for (int k = 0; k < 7; k++) begin
         p = gmul(p, p);
         r = gmul(r, p);
      end
      ginv = r;
   endfunction

   function automatic logic [7:0] rl(input logic [7:0] a, input int n);
      rl = (a << n) | (a >> (8 - n));
   endfunction

   // computed substitution trades area for no 256-entry table
   function automatic logic [7:0] sbox(input logic [7:0] a, input logic inv);
      logic [7:0] b;
      if (inv) begin
         b = rl(a, 1) ^ rl(a, 3) ^ rl(a, 6) ^ 8'h05;
         sbox = ginv(b);
      end else begin
         b = ginv(a);
         sbox = b ^ rl(b, 1) ^ rl(b, 2) ^ rl(b, 3) ^ rl(b, 4) ^ 8'h63;
      end
   endfunction

   // byte i of a block sits at bits 127-8i, column-major
   function automatic logic [127:0] sub_shift(input logic [127:0] s, input logic inv);
      logic [127:0] o;
      int src;
      o = '0;
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            src = inv ? (r + 4 * ((c - r + 4) % 4)) : (r + 4 * ((c + r) % 4));
            o[127 - 8 * (r + 4 * c) -: 8] = sbox(s[127 - 8 * src -: 8], inv);
         end
      end
      sub_shift = o;
   endfunction

   function automatic logic [127:0] mix(input logic [127:0] s, input logic inv);
      logic [127:0] o;
      logic [7:0] a [4];
      logic [7:0] k [4];
      o = '0;
      k[0] = inv ? 8'h0e : 8'h02;
      k[1] = inv ? 8'h0b : 8'h03;
      k[2] = inv ? 8'h0d : 8'h01;
      k[3] = inv ? 8'h09 : 8'h01;
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            a[r] = s[127 - 8 * (r + 4 * c) -: 8];
         end
         for (int r = 0; r < 4; r++) begin
            o[127 - 8 * (r + 4 * c) -: 8] = gmul(a[r], k[0]) ^ gmul(a[(r + 1) % 4], k[1])
               ^ gmul(a[(r + 2) % 4], k[2]) ^ gmul(a[(r + 3) % 4], k[3]);
         end
      end
      mix = o;
   endfunction

   function automatic logic [31:0] subrot(input logic [31:0] w, input logic [7:0] rc);
      subrot = {sbox(w[23:16], 1'b0) ^ rc, sbox(w[15:8], 1'b0), sbox(w[7:0], 1'b0),
         sbox(w[31:24], 1'b0)};
   endfunction

   // one key schedule step forward, or back to the previous round key
   function automatic logic [127:0] key_step(input logic [127:0] k, input logic [7:0] rc,
      input logic back);
      logic [31:0] w0;
      logic [31:0] w1;
      logic [31:0] w2;
      logic [31:0] w3;
      if (back) begin
         w3 = k[31:0] ^ k[63:32];
         w2 = k[63:32] ^ k[95:64];
         w1 = k[95:64] ^ k[127:96];
         w0 = k[127:96] ^ subrot(w3, rc);
      end else begin
         w0 = k[127:96] ^ subrot(k[31:0], rc);
         w1 = k[95:64] ^ w0;
         w2 = k[63:32] ^ w1;
         w3 = k[31:0] ^ w2;
      end
      key_step = {w0, w1, w2, w3};
   endfunction

   // merge one bus word into a 128-bit memory, plain or XOR load
   function automatic logic [127:0] merge(input logic [127:0] m, input logic [1:0] wi,
      input logic [31:0] d, input logic [3:0] be, input logic xo);
      logic [127:0] o;
      o = m;
      for (int l = 0; l < 4; l++) begin
         if (be[l]) begin
            o[127 - 8 * (4 * wi + l) -: 8] = xo ? (m[127 - 8 * (4 * wi + l) -: 8]
               ^ d[8 * l +: 8]) : d[8 * l +: 8];
         end
      end
      merge = o;
   endfunction

   // bus side registers
   logic aw_got, next_aw_got;
   logic w_got, next_w_got;
   logic [ABE_ADDR_W-1:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic bvalid, next_bvalid;
   logic [1:0] bresp, next_bresp;
   logic rvalid, next_rvalid;
   logic [1:0] rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   // configuration and memories
   abe_ctrl_t ctrl, next_ctrl;
   logic done, next_done;
   logic irq_en, next_irq_en;
   logic [127:0] key_mem, next_key_mem;
   logic [127:0] st, next_st;
   // engine sequencing
   abe_state_t fsm, next_fsm;
   logic [8:0] cnt, next_cnt;
   logic [127:0] rk, next_rk;
   logic [7:0] rc, next_rc;
   logic irq_q, next_irq;
   logic trig_q, next_trig;
   logic awready_q, next_awready; // registered write channel readies
   logic wready_q, next_wready;
   logic arready_q, next_arready; // registered read channel ready
   // combinational helpers
   logic wr_do;
   logic start;
   logic [7:0] wa;
   logic [7:0] ra;
   logic [127:0] t;
   logic [127:0] bus_st; // state memory after any bus write, before the engine

   // write and read channel handling, register writes, start decision
   always_comb begin
      next_aw_got = aw_got;
      next_w_got = w_got;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      next_ctrl = ctrl;
      next_irq_en = irq_en;
      next_key_mem = key_mem;
      bus_st = st;
      start = 1'b0;
      wa = aw_addr;
      ra = s_axi_araddr;
      // address and data may arrive in either order
      if (s_axi_awvalid && !aw_got && !bvalid) begin
         next_aw_got = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got && !bvalid) begin
         next_w_got = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (s_axi_bready && bvalid) begin
         next_bvalid = 1'b0;
      end
      wr_do = aw_got && w_got && !bvalid;
      if (wr_do) begin
         next_aw_got = 1'b0;
         next_w_got = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = ABE_RESP_OKAY;
         if (wa == ABE_OFF_CTRL) begin
            if (w_strb[0]) begin
               next_ctrl.decrypt = w_data[ABE_CTRL_DECRYPT];
               next_ctrl.auto_start = w_data[ABE_CTRL_AUTO];
               next_ctrl.xor_load = w_data[ABE_CTRL_XOR];
               start = w_data[ABE_CTRL_START];
            end
         end else if (wa == ABE_OFF_STATUS) begin
            // done clear handled with the engine
         end else if (wa == ABE_OFF_IRQ_MASK) begin
            if (w_strb[0]) begin
               next_irq_en = w_data[0];
            end
         end else if (wa[7:4] == ABE_OFF_KEY[7:4] && wa[1:0] == 2'h0) begin
            next_key_mem = merge(key_mem, wa[3:2], w_data, w_strb, 1'b0);
         end else if (wa[7:4] == ABE_OFF_STATE[7:4] && wa[1:0] == 2'h0) begin
            // state is the working register; writes during an operation are dropped
            if (fsm == ABE_IDLE) begin
               bus_st = merge(st, wa[3:2], w_data, w_strb, ctrl.xor_load);
               if (ctrl.auto_start && wa[3:2] == 2'h3 && w_strb[3]) begin
                  start = 1'b1;
               end
            end
         end else begin
            next_bresp = ABE_RESP_SLVERR;
         end
      end
      // read answer one cycle after the address is taken
      if (s_axi_rready && rvalid) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && !rvalid) begin
         next_rvalid = 1'b1;
         next_rresp = ABE_RESP_OKAY;
         next_rdata = 32'h0000_0000;
         if (ra == ABE_OFF_CTRL) begin
            next_rdata[ABE_CTRL_DECRYPT] = ctrl.decrypt;
            next_rdata[ABE_CTRL_AUTO] = ctrl.auto_start;
            next_rdata[ABE_CTRL_XOR] = ctrl.xor_load;
         end else if (ra == ABE_OFF_STATUS) begin
            next_rdata[ABE_STAT_DONE] = done;
            next_rdata[ABE_STAT_BUSY] = (fsm == ABE_BUSY);
         end else if (ra == ABE_OFF_IRQ_MASK) begin
            next_rdata[0] = irq_en;
         end else if (ra[7:4] == ABE_OFF_KEY[7:4] && ra[1:0] == 2'h0) begin
            // key memory is write only
         end else if (ra[7:4] == ABE_OFF_STATE[7:4] && ra[1:0] == 2'h0) begin
            // intermediate rounds never leak; zero until the result stands
            if (fsm == ABE_IDLE) begin
               for (int l = 0; l < 4; l++) begin
                  next_rdata[8 * l +: 8] = st[127 - 8 * (4 * ra[3:2] + l) -: 8];
               end
            end
         end else begin
            next_rresp = ABE_RESP_SLVERR;
         end
      end
      if (fsm == ABE_BUSY) begin
         start = 1'b0;
      end
      // readies registered so every port comes from a flop
      next_awready = !next_aw_got && !next_bvalid;
      next_wready = !next_w_got && !next_bvalid;
      next_arready = !next_rvalid;
   end

   // cipher sequencing: rounds run early, completion waits for the fixed latency
   always_comb begin
      next_fsm = fsm;
      next_cnt = cnt;
      next_rk = rk;
      next_rc = rc;
      next_done = done;
      next_trig = 1'b0;
      t = '0;
      // engine owns the state register; bus writes only land while idle
      next_st = bus_st;
      // software clear first so a completion in the same cycle wins
      if (wr_do && wa == ABE_OFF_STATUS && w_strb[0] && w_data[ABE_STAT_DONE]) begin
         next_done = 1'b0;
      end
      case (fsm)
         ABE_IDLE: begin
            if (start) begin
               next_fsm = ABE_BUSY;
               next_cnt = 9'h000;
               next_rk = key_mem;
               next_rc = ABE_RCON_FIRST;
               next_done = 1'b0;
            end
         end
         ABE_BUSY: begin
            next_cnt = cnt + 9'h001;
            if (!ctrl.decrypt) begin
               // encryption: initial key add then ten rounds
               if (cnt == 9'h000) begin
                  next_st = st ^ rk;
               end else if (cnt <= ABE_ENC_LAST) begin
                  next_rk = key_step(rk, rc, 1'b0);
                  next_rc = xt(rc);
                  t = sub_shift(st, 1'b0);
                  if (cnt != ABE_ENC_LAST) begin
                     t = mix(t, 1'b0);
                  end
                  next_st = t ^ next_rk;
               end
            end else begin
               // decryption: walk the key forward, then unwind rounds
               if (cnt < ABE_DEC_KEY_END) begin
                  next_rk = key_step(rk, rc, 1'b0);
                  next_rc = xt(rc);
               end else if (cnt == ABE_DEC_KEY_END) begin
                  next_st = st ^ rk;
                  next_rc = ABE_RCON_LAST;
               end else if (cnt <= ABE_DEC_LAST) begin
                  next_rk = key_step(rk, rc, 1'b1);
                  next_rc = rc[0] ? (((rc ^ 8'h1b) >> 1) | 8'h80) : (rc >> 1);
                  t = sub_shift(st, 1'b1) ^ next_rk;
                  if (cnt != ABE_DEC_LAST) begin
                     t = mix(t, 1'b1);
                  end
                  next_st = t;
               end
            end
            if (cnt == ABE_OP_CYCLES - 9'h001) begin
               next_fsm = ABE_IDLE;
               next_done = 1'b1;
               next_trig = 1'b1;
            end
         end
         default: begin
            next_fsm = ABE_IDLE;
         end
      endcase
      next_irq = next_done && next_irq_en;
   end

   // register everything; reset leaves the engine idle with nothing pending
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         bvalid <= 1'b0;
         bresp <= ABE_RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= ABE_RESP_OKAY;
         rdata <= '0;
         ctrl <= ABE_CTRL_RESET;
         done <= 1'b0;
         irq_en <= 1'b0;
         key_mem <= '0;
         st <= '0;
         fsm <= ABE_IDLE;
         cnt <= '0;
         rk <= '0;
         rc <= '0;
         irq_q <= 1'b0;
         trig_q <= 1'b0;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         arready_q <= 1'b1;
      end else begin
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         ctrl <= next_ctrl;
         done <= next_done;
         irq_en <= next_irq_en;
         key_mem <= next_key_mem;
         st <= next_st;
         fsm <= next_fsm;
         cnt <= next_cnt;
         rk <= next_rk;
         rc <= next_rc;
         irq_q <= next_irq;
         trig_q <= next_trig;
         awready_q <= next_awready;
         wready_q <= next_wready;
         arready_q <= next_arready;
      end
   end

   // outputs straight from flops
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rresp = rresp;
   assign s_axi_rdata = rdata;
   assign irq = irq_q;
   assign dma_trig = trig_q;
endmodule
`default_nettype wire

// [hw/abe_pkg.sv]
// package: register map, field positions, reset values and types of the block cipher engine
package abe_pkg;
   // bus geometry
   localparam int ABE_ADDR_W = 8;
   localparam int ABE_DATA_W = 32;
   // register byte offsets
   localparam logic [7:0] ABE_OFF_CTRL = 8'h00;
   localparam logic [7:0] ABE_OFF_STATUS = 8'h04;
   localparam logic [7:0] ABE_OFF_IRQ_MASK = 8'h08;
   localparam logic [7:0] ABE_OFF_KEY = 8'h10;
   localparam logic [7:0] ABE_OFF_STATE = 8'h20;
   // control field positions
   localparam int ABE_CTRL_START = 0;
   localparam int ABE_CTRL_DECRYPT = 1;
   localparam int ABE_CTRL_AUTO = 2;
   localparam int ABE_CTRL_XOR = 3;
   // status field positions
   localparam int ABE_STAT_DONE = 0;
   localparam int ABE_STAT_BUSY = 1;
   // cycle counts
   localparam logic [8:0] ABE_OP_CYCLES = 9'h177;
   localparam logic [8:0] ABE_ENC_LAST = 9'h00a;
   localparam logic [8:0] ABE_DEC_KEY_END = 9'h00a;
   localparam logic [8:0] ABE_DEC_LAST = 9'h014;
   // round constants
   localparam logic [7:0] ABE_RCON_FIRST = 8'h01;
   localparam logic [7:0] ABE_RCON_LAST = 8'h36;
   // bus responses
   localparam logic [1:0] ABE_RESP_OKAY = 2'h0;
   localparam logic [1:0] ABE_RESP_SLVERR = 2'h2;
   // software configuration bits
   typedef struct packed {
      logic xor_load;
      logic auto_start;
      logic decrypt;
   } abe_ctrl_t;
   localparam abe_ctrl_t ABE_CTRL_RESET = '0;
   // engine sequencing
   typedef enum logic [0:0] {
      ABE_IDLE = 1'b0,
      ABE_BUSY = 1'b1
   } abe_state_t;
endpackage

// [hw/abe_unused_note.sv]
// spare design unit with no logic; the whole engine lives in abe_engine
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [verif/abe_engine_monitor.sv]
// port checker of the block cipher engine
`timescale 1ns/10ps
`default_nettype none
module abe_engine_monitor
   import abe_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [ABE_DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic irq,
   input wire logic dma_trig
);
   logic [8:0] gap; // cycles since the last completion pulse
   logic [8:0] next_gap;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // saturating spacing counter, cleared by each pulse
   always_comb begin
      next_gap = gap;
      if (dma_trig) begin
         next_gap = 9'h000;
      end else if (gap != 9'h1ff) begin
         next_gap = gap + 9'h001;
      end
   end
   // reset value lets the first pulse through
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gap <= 9'h1ff;
      end else begin
         gap <= next_gap;
      end
   end
   AST_TRIG_PULSE: assert property (dma_trig |=> !dma_trig)
      else $error("completion trigger longer than one cycle");
   AST_OP_SPACING: assert property (dma_trig |-> gap >= 9'h176)
      else $error("two completions closer than one operation");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before accepted");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read response dropped before accepted");
   AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("new write taken while response pending");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("new read taken while response pending");
   AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   cover property (dma_trig && irq);
   cover property (dma_trig && !irq);
   cover property (s_axi_bvalid && s_axi_bresp == ABE_RESP_SLVERR);
endmodule
bind abe_engine abe_engine_monitor mon (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .irq(irq), .dma_trig(dma_trig));
`default_nettype wire

// [verif/abe_bus_model.sv]
// bus master model standing in for the processor or dma side
`timescale 1ns/10ps
`default_nettype none
module abe_bus_model
   import abe_pkg::*;
(
   input wire logic aclk,
   output logic [ABE_ADDR_W-1:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [ABE_DATA_W-1:0] wdata,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [ABE_ADDR_W-1:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [ABE_DATA_W-1:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   // idle bus at time zero
   initial begin
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
   end
   // one write; response accepted one edge late, so the slave must hold it
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
      output logic ok);
      int n;
      begin
         ok = 1'b0;
         r = 2'h3;
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         for (n = 0; n < 40 && !ok; n++) begin
            @(posedge aclk);
            if (awvalid && awready) begin
               awvalid <= 1'b0;
               awaddr <= ~a; // released lines stop showing the old value
            end
            if (wvalid && wready) begin
               wvalid <= 1'b0;
               wdata <= ~d;
            end
            if (bvalid && bready) begin
               r = bresp;
               ok = 1'b1;
               bready <= 1'b0;
            end else if (bvalid) begin
               bready <= 1'b1;
            end
         end
      end
   endtask
   // one read, accepted one edge late as well
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
      output logic ok);
      int n;
      begin
         ok = 1'b0;
         araddr <= a;
         arvalid <= 1'b1;
         for (n = 0; n < 40 && !ok; n++) begin
            @(posedge aclk);
            if (arvalid && arready) begin
               arvalid <= 1'b0;
               araddr <= ~a;
            end
            if (rvalid && rready) begin
               d = rdata;
               r = rresp;
               ok = 1'b1;
               rready <= 1'b0;
            end else if (rvalid) begin
               rready <= 1'b1;
            end
         end
      end
   endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench of the block cipher engine
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import abe_pkg::*;
;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] rsp; logic [31:0] rd;} abe_row_t;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq, dma_trig;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   int fails, n_compared, t0, i;
   int cyc = 0; // free edge count, written only by its clocked process
   // known-answer vector, byte 0 in lane 0
   logic [31:0] key [4] = '{32'h03020100, 32'h07060504, 32'h0b0a0908, 32'h0f0e0d0c};
   logic [31:0] pt [4] = '{32'h33221100, 32'h77665544, 32'hbbaa9988, 32'hffeeddcc};
   logic [31:0] ct [4] = '{32'hd8e0c469, 32'h30047b6a, 32'h80b7cdd8, 32'h5ac5b470};
   // address, write data, response, readback
   abe_row_t rows [9] = '{'{8'h08, 32'h1, 2'h0, 32'h1}, '{8'h00, 32'ha, 2'h0, 32'ha},
      '{8'h00, 32'h0, 2'h0, 32'h0}, '{8'h20, 32'ha5a5a5a5, 2'h0, 32'ha5a5a5a5},
      '{8'h10, 32'h12345678, 2'h0, 32'h0}, '{8'h04, 32'h0, 2'h0, 32'h0},
      '{8'h0c, 32'hff, 2'h2, 32'h0}, '{8'h30, 32'h1, 2'h2, 32'h0}, '{8'h12, 32'h1, 2'h2, 32'h0}};
   abe_engine uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .irq(irq), .dma_trig(dma_trig));
   abe_bus_model m (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready));
   // 20 mhz clock and a free edge count
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk) cyc <= cyc + 1;
   task automatic finish_test();
      if (fails == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic [1:0] r;
      logic ok;
      m.wr(a, d, r, ok);
      if (!ok) begin
         fails++;
         finish_test();
      end
      chk("bresp", {30'h0, e}, {30'h0, r});
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      logic ok;
      m.rd(a, d, r, ok);
      if (!ok) begin
         fails++;
         finish_test();
      end
      chk("rdata", e, d);
      chk("rresp", {30'h0, er}, {30'h0, r});
   endtask
   // wait for the completion pulse; response taken two edges after the start lands
   task automatic wait_done(input logic ei);
      int n;
      for (n = 0; n < 500 && !dma_trig; n++) @(posedge aclk);
      if (n == 500) begin
         fails++;
         finish_test();
      end
      chk("latency", 32'h176, 32'(cyc - t0));
      chk("irq", {31'h0, ei}, {31'h0, irq});
   endtask
   initial begin
      fails = 0;
      n_compared = 0;
      aresetn = 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("reset_irq", 32'h0, {31'h0, irq});
      rchk(ABE_OFF_STATUS, 32'h0, ABE_RESP_OKAY);
      for (i = 0; i < 9; i++) begin
         wchk(rows[i].a, rows[i].d, rows[i].rsp);
         rchk(rows[i].a, rows[i].rd, rows[i].rsp);
      end
      // encrypt with completion interrupt on
      for (i = 0; i < 4; i++) wchk(ABE_OFF_KEY + 8'(4 * i), key[i], ABE_RESP_OKAY);
      for (i = 0; i < 4; i++) wchk(ABE_OFF_STATE + 8'(4 * i), pt[i], ABE_RESP_OKAY);
      wchk(ABE_OFF_IRQ_MASK, 32'h1, ABE_RESP_OKAY);
      wchk(ABE_OFF_CTRL, 32'h1, ABE_RESP_OKAY);
      t0 = cyc;
      rchk(ABE_OFF_STATE, 32'h0, ABE_RESP_OKAY);
      rchk(ABE_OFF_STATUS, 32'h2, ABE_RESP_OKAY);
      wait_done(1'b1);
      for (i = 0; i < 4; i++) rchk(ABE_OFF_STATE + 8'(4 * i), ct[i], ABE_RESP_OKAY);
      rchk(ABE_OFF_STATUS, 32'h1, ABE_RESP_OKAY);
      wchk(ABE_OFF_STATUS, 32'h1, ABE_RESP_OKAY);
      rchk(ABE_OFF_STATUS, 32'h0, ABE_RESP_OKAY);
      chk("irq_clear", 32'h0, {31'h0, irq});
      // decrypt, auto-started by the last state word, interrupt masked
      wchk(ABE_OFF_IRQ_MASK, 32'h0, ABE_RESP_OKAY);
      wchk(ABE_OFF_CTRL, 32'h6, ABE_RESP_OKAY);
      wchk(ABE_OFF_STATE + 8'h0c, ct[3], ABE_RESP_OKAY);
      t0 = cyc;
      rchk(ABE_OFF_STATUS, 32'h2, ABE_RESP_OKAY);
      wait_done(1'b0);
      for (i = 0; i < 4; i++) rchk(ABE_OFF_STATE + 8'(4 * i), pt[i], ABE_RESP_OKAY);
      wchk(ABE_OFF_IRQ_MASK, 32'h1, ABE_RESP_OKAY);
      @(posedge aclk);
      chk("irq_unmask", 32'h1, {31'h0, irq});
      // xor load on a stored word
      wchk(ABE_OFF_CTRL, 32'h8, ABE_RESP_OKAY);
      wchk(ABE_OFF_STATE, 32'hffffffff, ABE_RESP_OKAY);
      rchk(ABE_OFF_STATE, ~pt[0], ABE_RESP_OKAY);
      // reset in mid-operation: engine idle again, memories and flags cleared
      wchk(ABE_OFF_CTRL, 32'h1, ABE_RESP_OKAY);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(ABE_OFF_STATUS, 32'h0, ABE_RESP_OKAY);
      rchk(ABE_OFF_STATE, 32'h0, ABE_RESP_OKAY);
      chk("midrun_irq", 32'h0, {31'h0, irq});
      chk("midrun_trig", 32'h0, {31'h0, dma_trig});
      finish_test();
   end
endmodule
`default_nettype wire
